// [src/tswc_pkg.sv]
/*
 * constants, field layout and carrier types of the stop-window and
 * timeout configuration bank of the time-to-digital converter.
 * assumes a 100 MHz system clock and a 4 MHz high-speed reference.
 */
// Function
// - auto-sum bit set in range 2 sums all pulse results into result.
// - bit 30 selects first-wave layout for both registers, else normal layout.
// - error-value bit forces result to all ones on timeout.
// - two-bit code picks 64, 256, 1024 or 4096 us at 4 MHz; reset 3.
// - normal mode: second stop-enable delay, 14.5 fixed point from start.
// - normal mode: third stop-enable delay; upper five bits kept at 2.
// - low byte of both registers is free storage without effect.
// - first-wave: third stop period count, 5 to 63, above second.
// - first-wave: second stop period count, 4 to 63, above first.
// - first-wave: first stop period count, 3 to 63.
// - first-wave: bit 16 zero enables pulse-width measure, one disables.
// - first-wave: bit 15 picks rising (0) or falling (1) detection edge.
// - first-wave: bit 14 adds plus 20 mV comparator offset.
// - first-wave: bit 13 adds minus 20 mV comparator offset.
// - first-wave: five-bit two's complement fine offset in 1 mV steps.
// - all three stop delays share format and start reference.
package tswc_pkg;
    // register map, byte addresses are four times the index
    localparam int         ADDR_W      = 8;
    localparam logic [7:0] IDX_CFG3    = 8'h03;
    localparam logic [7:0] IDX_CFG4    = 8'h04;
    localparam logic [7:0] ADDR_CFG3   = {IDX_CFG3[5:0], 2'h0};
    localparam logic [7:0] ADDR_CFG4   = {IDX_CFG4[5:0], 2'h0};
    localparam logic [7:0] ADDR_STATUS = 8'h20;
    localparam logic [7:0] ADDR_RESULT = 8'h24;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam logic [31:0] CFG3_RST = 32'h1800_0000;
    localparam logic [31:0] CFG4_RST = 32'h1000_0000;

    // fields
    localparam int AUTOSUM_BIT = 31;
    localparam int FW_BIT      = 30;
    localparam int ERRVAL_BIT  = 29;
    localparam int TIMO_LSB    = 27;
    localparam int DELAY_LSB   = 8;
    localparam int DELAY_W     = 19;
    localparam int CNT_W       = 6;
    localparam int CNT1_LSB    = 8;
    localparam int CNT2_LSB    = 14;
    localparam int CNT3_LSB    = 20;
    localparam int PWDIS_BIT   = 16;
    localparam int EDGE_BIT    = 15;
    localparam int OFFP_BIT    = 14;
    localparam int OFFM_BIT    = 13;
    localparam int COMPARATOR_FINE_OFFSET_LSB    = 8;
    localparam int COMPARATOR_FINE_OFFSET_W      = 5;
    localparam int OFFSET_W    = 7;
    localparam logic [5:0] CNT1_MIN = 6'h03;
    localparam logic [5:0] CNT2_MIN = 6'h04;
    localparam logic [5:0] CNT3_MIN = 6'h05;
    localparam logic signed [6:0] COMPARATOR_FINE_OFFSET_COARSE_MV = 7'sh14;

    // status bits
    localparam int ST_FW      = 0;
    localparam int ST_BUSY    = 1;
    localparam int ST_TIMER   = 2;
    localparam int ST_TIMEOUT = 3;
    localparam int ST_CNTERR  = 4;

    // timing
    localparam int CLK_HZ    = 100_000_000;
    localparam int HS_CLK_HZ = 4_000_000;
    localparam int HS_DIV    = CLK_HZ / HS_CLK_HZ;
    localparam int TIMO_US0  = 64;
    localparam int TIMO_US1  = 256;
    localparam int TIMO_US2  = 1024;
    localparam int TIMO_US3  = 4096;
    localparam int TICK_W    = 15;
    localparam logic [14:0] TIMO_TICKS0 = 15'(TIMO_US0 * (HS_CLK_HZ / 1_000_000));
    localparam logic [14:0] TIMO_TICKS1 = 15'(TIMO_US1 * (HS_CLK_HZ / 1_000_000));
    localparam logic [14:0] TIMO_TICKS2 = 15'(TIMO_US2 * (HS_CLK_HZ / 1_000_000));
    localparam logic [14:0] TIMO_TICKS3 = 15'(TIMO_US3 * (HS_CLK_HZ / 1_000_000));

    typedef struct packed {
        logic              first_wave;
        logic [18:0]       delay1;
        logic [18:0]       delay2;
        logic [18:0]       delay3;
        logic [5:0]        count1;
        logic [5:0]        count2;
        logic [5:0]        count3;
    } tswc_stop_cfg_t;

    typedef struct packed {
        logic              pw_enable;
        logic              edge_falling;
        logic signed [6:0] offset_mv;
    } tswc_cmp_cfg_t;
endpackage

// [src/tswc_timeout.sv]
/*
 * range-2 timeout timer: counts high-speed clock ticks derived from
 * aclk by a divider and pulses expired when the selected span ends.
 * assumes start and stop are single-cycle pulses on aclk.
 */
`timescale 1ns/1ps
module tswc_timeout #(
    parameter int HS_DIV = tswc_pkg::HS_DIV
) (
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // control
    input  wire logic       start,
    input  wire logic       stop,
    input  wire logic [1:0] sel,
    // state
    output logic            running,
    output logic            expired
);
    logic [7:0]  div_cnt;
    logic [14:0] tick_cnt;
    logic [14:0] limit;
    logic [14:0] next_limit;
    wire         hs_tick  = running && (div_cnt == 8'(HS_DIV - 1));
    wire         last_tck = hs_tick && (tick_cnt == limit - 15'h1);

    always_comb begin
        case (sel)
            2'h0:    next_limit = tswc_pkg::TIMO_TICKS0;
            2'h1:    next_limit = tswc_pkg::TIMO_TICKS1;
            2'h2:    next_limit = tswc_pkg::TIMO_TICKS2;
            default: next_limit = tswc_pkg::TIMO_TICKS3;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            running  <= 1'b0;
            expired  <= 1'b0;
            div_cnt  <= 8'h0;
            tick_cnt <= 15'h0;
            limit    <= tswc_pkg::TIMO_TICKS3;
        end else if (start) begin
            running  <= 1'b1;
            expired  <= 1'b0;
            div_cnt  <= 8'h0;
            tick_cnt <= 15'h0;
            limit    <= next_limit;
        end else begin
            expired <= last_tck;
            if (stop || last_tck) begin
                running <= 1'b0;
            end
            if (running) begin
                div_cnt <= hs_tick ? 8'h0 : div_cnt + 8'h1;
            end
            if (hs_tick) begin
                tick_cnt <= tick_cnt + 15'h1;
            end
        end
    end

    a_limit_code: assert property (
        @(posedge aclk) disable iff (!aresetn)
        start && sel == 2'h0 |=> limit == 15'h100)
        else $error("timeout code 0 must give 256 ticks");

    a_expire_count: assert property (
        @(posedge aclk) disable iff (!aresetn)
        expired |-> $past(tick_cnt) == $past(limit) - 15'h1 && $past(hs_tick))
        else $error("timeout fired before the selected span");
endmodule

// [src/tswc_regs.sv]
/*
 * stop-window, timeout and comparator-offset configuration bank with
 * an axi4-lite slave, result capture for every measurement, auto-sum and timeout in range 2.
 * assumes the measurement core runs on aclk and pulses meas_start,
 * hit_valid and meas_done for one cycle each.
 */
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module tswc_regs #(
    parameter int HS_DIV = tswc_pkg::HS_DIV
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // measurement core
    input  wire logic [18:0] first_stop_delay,
    input  wire logic        range2_active,
    input  wire logic        meas_start,
    input  wire logic        meas_done,
    input  wire logic        hit_valid,
    input  wire logic [31:0] hit_value,
    // configuration and results
    output tswc_pkg::tswc_stop_cfg_t stop_cfg,
    output tswc_pkg::tswc_cmp_cfg_t  cmp_cfg,
    output logic [31:0]      result_value,
    output logic             result_valid,
    output logic             timeout_flag
);
    logic [31:0] cfg3;
    logic [31:0] cfg4;
    logic        aw_held;
    logic        w_held;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        busy;
    logic        timed_out;
    logic [31:0] accum;
    logic [31:0] last_hit;
    logic        timer_running;
    logic        timer_expired;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = data[8*i +: 8];
            end
        end
        return res;
    endfunction

    // write path: address and data may arrive in either order
    wire aw_take  = s_axi_awvalid && s_axi_awready;
    wire w_take   = s_axi_wvalid && s_axi_wready;
    wire wr_go    = aw_held && w_held && !s_axi_bvalid;
    wire b_take   = s_axi_bvalid && s_axi_bready;
    wire hit3_w   = wr_addr == tswc_pkg::ADDR_CFG3;
    wire hit4_w   = wr_addr == tswc_pkg::ADDR_CFG4;
    wire ro_w     = wr_addr == tswc_pkg::ADDR_STATUS || wr_addr == tswc_pkg::ADDR_RESULT;
    wire wr_ok    = hit3_w || hit4_w || ro_w;
    // the free tag bytes are stored like any other field and read back
    wire [31:0] next_cfg3 = (wr_go && hit3_w) ? merge(cfg3, wr_data, wr_strb) : cfg3;
    wire [31:0] next_cfg4 = (wr_go && hit4_w) ? merge(cfg4, wr_data, wr_strb) : cfg4;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg3 <= tswc_pkg::CFG3_RST;
            cfg4 <= tswc_pkg::CFG4_RST;
        end else begin
            cfg3 <= next_cfg3;
            cfg4 <= next_cfg4;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            wr_addr       <= 8'h0;
            wr_data       <= 32'h0;
            wr_strb       <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= tswc_pkg::RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_held       <= 1'b1;
                wr_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_take) begin
                w_held       <= 1'b1;
                wr_data      <= s_axi_wdata;
                wr_strb      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? tswc_pkg::RESP_OKAY : tswc_pkg::RESP_SLVERR;
            end
            // ready comes back only after the response, one write at a time
            if (b_take) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // decode of the two layouts
    wire        fw_mode = cfg3[tswc_pkg::FW_BIT];
    wire [5:0]  cnt1    = cfg3[tswc_pkg::CNT1_LSB +: tswc_pkg::CNT_W];
    wire [5:0]  cnt2    = cfg3[tswc_pkg::CNT2_LSB +: tswc_pkg::CNT_W];
    wire [5:0]  cnt3    = cfg3[tswc_pkg::CNT3_LSB +: tswc_pkg::CNT_W];
    // software owns the ordering; out-of-range counts are only reported
    wire        cnt_err = fw_mode && (cnt1 < tswc_pkg::CNT1_MIN
                          || cnt2 < tswc_pkg::CNT2_MIN || cnt2 <= cnt1
                          || cnt3 < tswc_pkg::CNT3_MIN || cnt3 <= cnt2);
    wire [4:0]  fine    = cfg4[tswc_pkg::COMPARATOR_FINE_OFFSET_LSB +: tswc_pkg::COMPARATOR_FINE_OFFSET_W];
    wire signed [6:0] fine_mv  = {{2{fine[4]}}, fine};
    wire signed [6:0] plus_mv  = cfg4[tswc_pkg::OFFP_BIT] ? tswc_pkg::COMPARATOR_FINE_OFFSET_COARSE_MV : 7'sh0;
    wire signed [6:0] minus_mv = cfg4[tswc_pkg::OFFM_BIT] ? tswc_pkg::COMPARATOR_FINE_OFFSET_COARSE_MV : 7'sh0;
    wire [18:0] dly2 = cfg3[tswc_pkg::DELAY_LSB +: tswc_pkg::DELAY_W];
    wire [18:0] dly3 = cfg4[tswc_pkg::DELAY_LSB +: tswc_pkg::DELAY_W];

    tswc_pkg::tswc_stop_cfg_t next_stop;
    tswc_pkg::tswc_cmp_cfg_t  next_cmp;
    // all three delays pass the same register stage so they line up
    assign next_stop.first_wave = fw_mode;
    assign next_stop.delay1     = fw_mode ? 19'h0 : first_stop_delay;
    assign next_stop.delay2     = fw_mode ? 19'h0 : dly2;
    assign next_stop.delay3     = fw_mode ? 19'h0 : dly3;
    assign next_stop.count1     = fw_mode ? cnt1 : 6'h0;
    assign next_stop.count2     = fw_mode ? cnt2 : 6'h0;
    assign next_stop.count3     = fw_mode ? cnt3 : 6'h0;
    assign next_cmp.pw_enable    = fw_mode && !cfg4[tswc_pkg::PWDIS_BIT];
    assign next_cmp.edge_falling = fw_mode && cfg4[tswc_pkg::EDGE_BIT];
    assign next_cmp.offset_mv    = fw_mode ? fine_mv + plus_mv - minus_mv : 7'sh0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stop_cfg <= '0;
            cmp_cfg  <= '0;
        end else begin
            stop_cfg <= next_stop;
            cmp_cfg  <= next_cmp;
        end
    end

    // measurement result capture
    wire        autosum_on = cfg3[tswc_pkg::AUTOSUM_BIT] && range2_active;
    wire        err_on     = cfg3[tswc_pkg::ERRVAL_BIT];
    wire        hit_now    = busy && hit_valid;
    wire        done_now   = busy && meas_done;
    wire        tmo_now    = busy && timer_expired && !meas_done;
    wire [31:0] next_accum = accum + (hit_now ? hit_value : 32'h0);
    wire [31:0] next_last  = hit_now ? hit_value : last_hit;
    wire [31:0] partial    = autosum_on ? next_accum : next_last;
    wire [31:0] tmo_value  = err_on ? 32'hffff_ffff : partial;

    tswc_timeout #(
        .HS_DIV (HS_DIV)
    ) u_timeout (
        .aclk    (aclk),
        .aresetn (aresetn),
        .start   (meas_start && range2_active),
        // a restart outside range 2 must not inherit a running timer
        .stop    (done_now || (meas_start && !range2_active)),
        .sel     (cfg3[tswc_pkg::TIMO_LSB +: 2]),
        .running (timer_running),
        .expired (timer_expired)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy         <= 1'b0;
            timed_out    <= 1'b0;
            accum        <= 32'h0;
            last_hit     <= 32'h0;
            result_value <= 32'h0;
            result_valid <= 1'b0;
            timeout_flag <= 1'b0;
        end else begin
            result_valid <= 1'b0;
            timeout_flag <= 1'b0;
            if (meas_start) begin
                busy      <= 1'b1;
                timed_out <= 1'b0;
                accum     <= 32'h0;
                last_hit  <= 32'h0;
            end else if (done_now) begin
                busy         <= 1'b0;
                result_value <= partial;
                result_valid <= 1'b1;
            end else if (tmo_now) begin
                busy         <= 1'b0;
                timed_out    <= 1'b1;
                result_value <= tmo_value;
                result_valid <= 1'b1;
                timeout_flag <= 1'b1;
            end else begin
                accum    <= next_accum;
                last_hit <= next_last;
            end
        end
    end

    // read path, answered one cycle after the address is taken
    wire        ar_take = s_axi_arvalid && s_axi_arready;
    wire        r_take  = s_axi_rvalid && s_axi_rready;
    wire [31:0] status  = {27'h0, cnt_err, timed_out, timer_running, busy, fw_mode};
    wire        rd_ok   = s_axi_araddr == tswc_pkg::ADDR_CFG3
                       || s_axi_araddr == tswc_pkg::ADDR_CFG4
                       || s_axi_araddr == tswc_pkg::ADDR_STATUS
                       || s_axi_araddr == tswc_pkg::ADDR_RESULT;
    wire [31:0] rd_mux  = s_axi_araddr == tswc_pkg::ADDR_CFG3   ? cfg3 :
                          s_axi_araddr == tswc_pkg::ADDR_CFG4   ? cfg4 :
                          s_axi_araddr == tswc_pkg::ADDR_STATUS ? status :
                          s_axi_araddr == tswc_pkg::ADDR_RESULT ? result_value : 32'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= tswc_pkg::RESP_OKAY;
        end else if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_mux;
            s_axi_rresp   <= rd_ok ? tswc_pkg::RESP_OKAY : tswc_pkg::RESP_SLVERR;
        end else if (r_take) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    a_read_answer: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ar_take |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered in one cycle");

    a_write_answer: assert property (
        @(posedge aclk) disable iff (!aresetn)
        aw_take && w_take |=> wr_go ##1 s_axi_bvalid)
        else $error("write response not raised two cycles after take");

    a_reset_defaults: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $past(!aresetn) |-> cfg3 == 32'h1800_0000 && cfg4[31:27] == 5'h02 && !fw_mode)
        else $error("registers not at defaults after reset");

    a_layout_follow: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ##1 stop_cfg.first_wave == $past(cfg3[30])
            && (stop_cfg.first_wave || stop_cfg.count1 == 6'h0))
        else $error("layout does not follow the first-wave bit");

    a_normal_delay: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !cfg3[30] |=> stop_cfg.delay2 == $past(cfg3[26:8])
            && stop_cfg.delay3 == $past(cfg4[26:8]))
        else $error("normal-mode delays not passed on");

    a_tag_inert: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ##1 cfg3[31:8] == $past(cfg3[31:8]) && cfg4[31:8] == $past(cfg4[31:8])
            && first_stop_delay == $past(first_stop_delay)
        |=> $stable(stop_cfg) && $stable(cmp_cfg))
        else $error("tag byte changed the configuration outputs");

    a_offset_sum: assert property (
        @(posedge aclk) disable iff (!aresetn)
        cfg3[30] && cfg4[14:8] == 7'h5f |=> cmp_cfg.offset_mv == 7'sh13)
        else $error("plus 20 mV with -1 mV fine must give 19 mV");

    a_edge_pw: assert property (
        @(posedge aclk) disable iff (!aresetn)
        cfg3[30] |=> cmp_cfg.pw_enable == !$past(cfg4[16])
            && cmp_cfg.edge_falling == $past(cfg4[15]))
        else $error("pulse width or edge control wrong");

    a_autosum_result: assert property (
        @(posedge aclk) disable iff (!aresetn)
        done_now && !meas_start && autosum_on
        |=> result_valid && result_value == $past(next_accum))
        else $error("range-2 sum not written to result");

    a_error_force: assert property (
        @(posedge aclk) disable iff (!aresetn)
        tmo_now && !meas_start && err_on
        |=> result_value == 32'hffff_ffff && timeout_flag ##1 !timeout_flag)
        else $error("timeout did not force all ones");

    a_count_check: assert property (
        @(posedge aclk) disable iff (!aresetn)
        cfg3[30] && cfg3[13:8] < 6'h03 |-> status[4])
        else $error("first count below 3 not reported");

    a_fw_delays_zero: assert property (
        @(posedge aclk) disable iff (!aresetn)
        cfg3[30] |=> stop_cfg.delay1 == 19'h0 && stop_cfg.delay2 == 19'h0
            && stop_cfg.delay3 == 19'h0)
        else $error("delays not cleared in first-wave layout");

    a_normal_cmp_zero: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !cfg3[30] |=> cmp_cfg == 9'h0 && stop_cfg.count3 == 6'h0)
        else $error("first-wave fields active in normal layout");

    a_fine_offset: assert property (
        @(posedge aclk) disable iff (!aresetn)
        cfg3[30] && cfg4[14:13] == 2'h0 |=> cmp_cfg.offset_mv == $signed($past(cfg4[12:8])))
        else $error("fine offset not passed as two's complement");

    a_minus_coarse: assert property (
        @(posedge aclk) disable iff (!aresetn)
        cfg3[30] && cfg4[14:8] == 7'h2f |=> cmp_cfg.offset_mv == 7'h7b)
        else $error("minus 20 mV with 15 mV fine must give -5 mV");
endmodule

// [sim/tb.sv]
/*
 * self-checking bench for the stop-window configuration bank.
 * assumes tswc_regs with its axi4-lite slave; timer divider set to 1.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
    $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module tb;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, range2_active, meas_start;
    logic        meas_done, hit_valid, result_valid, timeout_flag;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, hit_value, result_value, d;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, r;
    logic [18:0] first_stop_delay;
    tswc_pkg::tswc_stop_cfg_t stop_cfg;
    tswc_pkg::tswc_cmp_cfg_t  cmp_cfg;
    int          fails, check_count, cyc, n;
    logic [4:0]  comparator_fine_offset_t[4] = '{5'h1f, 5'h0f, 5'h10, 5'h00};
    logic [1:0]  rng_t[4]  = '{2'b10, 2'b01, 2'b00, 2'b11};
    logic [6:0]  exp_t[4]  = '{7'h13, 7'h7b, 7'h70, 7'h00};

    tswc_regs #(.HS_DIV(1)) tswc_regs_inst (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .first_stop_delay(first_stop_delay), .range2_active(range2_active),
        .meas_start(meas_start), .meas_done(meas_done), .hit_valid(hit_valid),
        .hit_value(hit_value), .stop_cfg(stop_cfg), .cmp_cfg(cmp_cfg),
        .result_value(result_value), .result_valid(result_valid),
        .timeout_flag(timeout_flag));

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic end_sim();
        $display("mismatches %0d, comparisons %0d", fails, check_count);
        if (fails == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // a hung handshake never ends the wait loops, so the cycle ceiling does
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 30000) begin
            fails++;
            end_sim();
        end
    end

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= v;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (awready && !aw_ok) awvalid <= 1'b0;
            if (wready && !w_ok) wvalid <= 1'b0;
            aw_ok = aw_ok | awready;
            w_ok = w_ok | wready;
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
    endtask

    task automatic axi_rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
    endtask

    task automatic wait_res();
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (result_valid !== 1'b1);
    endtask

    // start, hits of 5 and 7, done; sum only when auto-sum applies in range 2
    task automatic meas(input logic r2, input logic [31:0] expv);
        range2_active <= r2;
        meas_start <= 1'b1;
        @(posedge aclk);
        meas_start <= 1'b0;
        hit_valid <= 1'b1;
        hit_value <= 32'h5;
        @(posedge aclk);
        hit_value <= 32'h7;
        @(posedge aclk);
        hit_valid <= 1'b0;
        meas_done <= 1'b1;
        @(posedge aclk);
        meas_done <= 1'b0;
        wait_res();
        `CHK(result_value, expv)
        `CHK(timeout_flag, 1'b0)
    endtask

    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {range2_active, meas_start, meas_done, hit_valid} = 4'h0;
        {awaddr, araddr, wdata, wstrb, hit_value} = 84'h0;
        first_stop_delay = 19'h7_1234;
        aresetn = 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_rd(tswc_pkg::ADDR_CFG3);
        `CHK({r, d}, {tswc_pkg::RESP_OKAY, 32'h1800_0000})
        axi_rd(tswc_pkg::ADDR_CFG4);
        `CHK(d, 32'h1000_0000)
        `CHK(stop_cfg.first_wave, 1'b0)
        axi_wr(tswc_pkg::ADDR_CFG3, {5'h02, 19'h5_a5a5, 8'h3c}, 4'hf);
        axi_wr(tswc_pkg::ADDR_CFG4, {5'h02, 19'h2_3456, 8'hc3}, 4'hf);
        axi_wr(tswc_pkg::ADDR_CFG4, 32'hffff_ff7e, 4'h1);
        repeat (2) @(posedge aclk);
        `CHK(stop_cfg.delay1, 19'h7_1234)
        `CHK(stop_cfg.delay2, 19'h5_a5a5)
        `CHK(stop_cfg.delay3, 19'h2_3456)
        `CHK({stop_cfg.count1, stop_cfg.count2, stop_cfg.count3, cmp_cfg}, 27'h0)
        axi_rd(tswc_pkg::ADDR_CFG4);
        `CHK(d, {5'h02, 19'h2_3456, 8'h7e})
        axi_wr(tswc_pkg::ADDR_CFG3, {3'b010, 2'h3, 1'b0, 6'h3f, 6'h04, 6'h03, 8'h5a}, 4'hf);
        for (int i = 0; i < 4; i++) begin
            axi_wr(tswc_pkg::ADDR_CFG4,
                   {5'h02, 10'h0, i[0], i[1], rng_t[i], comparator_fine_offset_t[i], 8'h00}, 4'hf);
            repeat (2) @(posedge aclk);
            `CHK(cmp_cfg, {~i[0], i[1], exp_t[i]})
        end
        `CHK(stop_cfg, {1'b1, 57'h0, 6'h03, 6'h04, 6'h3f})
        axi_wr(tswc_pkg::ADDR_CFG3, {3'b010, 2'h3, 1'b0, 6'h3f, 6'h04, 6'h02, 8'h5a}, 4'hf);
        axi_wr(tswc_pkg::ADDR_STATUS, 32'hffff_ffff, 4'hf);
        `CHK(r, tswc_pkg::RESP_OKAY)
        axi_rd(tswc_pkg::ADDR_STATUS);
        `CHK({r, d}, {tswc_pkg::RESP_OKAY, 32'h11})
        axi_wr(8'h40, 32'h1, 4'hf);
        `CHK(r, tswc_pkg::RESP_SLVERR)
        axi_rd(8'h40);
        `CHK({r, d}, {tswc_pkg::RESP_SLVERR, 32'h0})
        axi_wr(tswc_pkg::ADDR_CFG3, 32'h9800_0000, 4'hf);
        meas(1'b1, 32'hc);
        meas(1'b0, 32'h7);
        axi_wr(tswc_pkg::ADDR_CFG3, 32'h1800_0000, 4'hf);
        meas(1'b1, 32'h7);
        // timeout lengths for all codes with a divider of one, error value on odd codes
        for (int c = 0; c < 4; c++) begin
            axi_wr(tswc_pkg::ADDR_CFG3, {2'b00, c[0], c[1:0], 27'h0}, 4'hf);
            range2_active <= 1'b1;
            meas_start <= 1'b1;
            @(posedge aclk);
            meas_start <= 1'b0;
            wait_res();
            `CHK({timeout_flag, result_value}, {1'b1, (c[0] ? 32'hffff_ffff : 32'h0)})
            `CHK(n >= (256 << (2 * c)) && n <= (256 << (2 * c)) + 4, 1'b1)
        end
        axi_rd(tswc_pkg::ADDR_STATUS);
        `CHK({r, d}, {tswc_pkg::RESP_OKAY, 32'h8})
        axi_rd(tswc_pkg::ADDR_RESULT);
        `CHK(d, 32'hffff_ffff)
        end_sim();
    end
endmodule
